/* src/port_ctl_map.svh */
`ifndef PORT_CTL_MAP_SVH
`define PORT_CTL_MAP_SVH
// Behaviour
// - Link down on a port can force other ports' transmitters off per matrix.
// - OR combining: target transmitter off when any selected source reports loss.
// - AND combining: target transmitter off only when all selected sources report loss.
// - Single selected source: AND and OR give the same result.
// - Discard mode, the default: drop the frame after 16 collisions.
// - Restart mode: restart backoff instead of dropping after 16 collisions.
// - Laser shutoff while fiber receive signal is lost, when enabled; off after reset.
// - Per-port maximum frame length including FCS, up to 9600 bytes.
// - Switch mux modes hold the uplink at 2.5Gbps full duplex.
// - Mux disabled: speeds of ports one to three freely configurable.
// - VLAN mux: local port pairs only with matching remote port; no cross traffic.
// - Copper forced to 10/100 half or full, or 1G full duplex.
// - Fiber forced to 100M, 1G or 2.5G, always full duplex.
// - Auto setting: negotiate highest common speed; copper also negotiates duplex.
// - Pause obey and send follow last negotiation, when flow control is on.
// - Disabled speed setting stops all operation of the port; mux modes keep the uplink running at 2.5G regardless.
// - Receive and transmit packet and byte counters; clear zeroes all, then resumes.
// - Count receive and transmit frames dropped by congestion.
// - Count receive errors and incomplete transmissions.
// - Count receive frames filtered by forwarding.

`define REG_CTRL         12'h000
`define REG_LLF_BASE     12'h010
`define REG_PORT_BASE    12'h040
`define REG_STAT_BASE    12'h080
`define REG_CNT_BASE     12'h100
`define CNT_PER_PORT     8
`define CTRL_MUX_LSB     0
`define CTRL_CLR_BIT     4
`define LLF_MASK_LSB     0
`define LLF_AND_BIT      8
`define PCFG_SPD_LSB     0
`define PCFG_FC_BIT      4
`define PCFG_RESTART_BIT 5
`define PCFG_LASER_BIT   6
`define PCFG_MAXF_LSB    16
`define MAXF_RESET       14'h2580
`define COLL_LIMIT       5'h10
`endif

/* src/port_ctl_pkg.sv */
package port_ctl_pkg;
   typedef enum logic [1:0] {
      MUX_OFF = 2'h0,
      MUX_SWITCH = 2'h1,
      MUX_SWITCH_ISO = 2'h2,
      MUX_VLAN = 2'h3
   } mux_mode_t;
   typedef enum logic [2:0] {
      SPD_DISABLED = 3'h0,
      SPD_AUTO = 3'h1,
      SPD_10H = 3'h2,
      SPD_10F = 3'h3,
      SPD_100H = 3'h4,
      SPD_100F = 3'h5,
      SPD_1G = 3'h6,
      SPD_2G5 = 3'h7
   } speed_sel_t;
   typedef enum logic [1:0] {
      RATE_10 = 2'h0,
      RATE_100 = 2'h1,
      RATE_1G = 2'h2,
      RATE_2G5 = 2'h3
   } rate_t;
   typedef struct packed {
      logic       rx_frame;
      logic       rx_err;
      logic       rx_drop;
      logic       rx_filt;
      logic [13:0] rx_len;
      logic       tx_frame;
      logic       tx_drop;
      logic       tx_incomplete;
      logic [13:0] tx_len;
      logic       collision;
      logic       tx_done;
   } port_evt_t;
   typedef struct packed {
      logic       up;
      rate_t      rate;
      logic       full_dx;
      logic       tx_on;
      logic       rx_pause;
      logic       tx_pause;
      logic       laser_off;
   } port_stat_t;
   typedef struct packed {
      logic       valid;
      rate_t      rate;
      logic       full_dx;
      logic       pause_rx;
      logic       pause_tx;
   } aneg_t;
endpackage

/* src/port_link_loss_control.sv */
`timescale 1ns/100ps
`include "port_ctl_map.svh"
module port_link_loss_control #(
   parameter int NPORTS   = 5,
   parameter int FIBER_N  = 3,
   parameter int CNT_W    = 32,
   parameter int UPLINK   = 0
)(
   input  wire logic                          clk,
   input  wire logic                          rst_b,
   input  wire logic [11:0]                   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output      logic                          s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output      logic                          s_axi_wready,
   output      logic [1:0]                    s_axi_bresp,
   output      logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [11:0]                   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output      logic                          s_axi_arready,
   output      logic [31:0]                   s_axi_rdata,
   output      logic [1:0]                    s_axi_rresp,
   output      logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [NPORTS-1:0]             link_up,
   input  wire logic [NPORTS-1:0]             rx_loss,
   input  wire port_ctl_pkg::aneg_t [NPORTS-1:0] aneg,
   input  wire port_ctl_pkg::port_evt_t [NPORTS-1:0] evt,
   output      port_ctl_pkg::port_stat_t [NPORTS-1:0] stat,
   output      logic [NPORTS-1:0]             port_enable,
   output      logic [NPORTS-1:0]             tx_frame_drop,
   output      logic [NPORTS-1:0]             backoff_restart,
   output      logic [NPORTS-1:0]             rx_oversize,
   output      logic [NPORTS-1:0]             tx_oversize,
   output      logic [NPORTS-1:0][NPORTS-1:0] fwd_allow,
   output      logic                          vlan_tag_en
);
   localparam int NCNT = `CNT_PER_PORT;

   port_ctl_pkg::mux_mode_t               mux_reg;
   logic [NPORTS-1:0][NPORTS-1:0]         llf_mask_reg;
   logic [NPORTS-1:0]                     llf_and_reg;
   port_ctl_pkg::speed_sel_t [NPORTS-1:0] spd_reg;
   logic [NPORTS-1:0]                     fc_reg;
   logic [NPORTS-1:0]                     restart_reg;
   logic [NPORTS-1:0]                     laser_reg;
   logic [NPORTS-1:0][13:0]               maxf_reg;
   logic [NPORTS-1:0][4:0]                coll_reg;
   logic [CNT_W-1:0]                      cnt_reg [NPORTS*NCNT];
   logic                                  clr_pulse;

   // AXI write: accept address and data in either order, answer when both held
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [11:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_go;
   logic        wr_ok;
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         waddr_reg <= 12'h000;
         {wstrb_reg, wdata_reg} <= 36'h000000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            {wstrb_reg, wdata_reg} <= {s_axi_wstrb, s_axi_wdata};
         end
         if (wr_go)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end

   function automatic int port_of(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return int'(d[11:2]);
   endfunction

   always_comb
   begin
      wr_ok = 1'b0;
      if (waddr_reg == `REG_CTRL)
         wr_ok = 1'b1;
      else if (waddr_reg >= `REG_LLF_BASE && port_of(waddr_reg, `REG_LLF_BASE) < NPORTS)
         wr_ok = 1'b1;
      else if (waddr_reg >= `REG_PORT_BASE && port_of(waddr_reg, `REG_PORT_BASE) < NPORTS)
         wr_ok = 1'b1;
   end

   // Control register; the clear bit is a self-clearing strobe
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         mux_reg <= port_ctl_pkg::MUX_OFF;
         clr_pulse <= 1'b0;
      end
      else
      begin
         clr_pulse <= 1'b0;
         if (wr_go && waddr_reg == `REG_CTRL && wstrb_reg[0])
         begin
            mux_reg <= port_ctl_pkg::mux_mode_t'(wdata_reg[`CTRL_MUX_LSB +: 2]);
            clr_pulse <= wdata_reg[`CTRL_CLR_BIT];
         end
      end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         llf_mask_reg <= '0;
         llf_and_reg <= '0;
         spd_reg <= '{default: port_ctl_pkg::SPD_AUTO};
         fc_reg <= '0;
         restart_reg <= '0;
         laser_reg <= '0;
         maxf_reg <= {NPORTS{`MAXF_RESET}};
      end
      else if (wr_go)
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            if (waddr_reg == `REG_LLF_BASE + 12'(4*p))
            begin
               if (wstrb_reg[0])
                  llf_mask_reg[p] <= wdata_reg[`LLF_MASK_LSB +: NPORTS] & ~(NPORTS'(1) << p);
               if (wstrb_reg[1])
                  llf_and_reg[p] <= wdata_reg[`LLF_AND_BIT];
            end
            if (waddr_reg == `REG_PORT_BASE + 12'(4*p))
            begin
               if (wstrb_reg[0])
               begin
                  spd_reg[p] <= port_ctl_pkg::speed_sel_t'(wdata_reg[`PCFG_SPD_LSB +: 3]);
                  fc_reg[p] <= wdata_reg[`PCFG_FC_BIT];
                  restart_reg[p] <= wdata_reg[`PCFG_RESTART_BIT];
                  laser_reg[p] <= wdata_reg[`PCFG_LASER_BIT];
               end
               if (wstrb_reg[2] && wstrb_reg[3])
                  maxf_reg[p] <= (wdata_reg[`PCFG_MAXF_LSB +: 14] > `MAXF_RESET) ?
                                 `MAXF_RESET : wdata_reg[`PCFG_MAXF_LSB +: 14];
            end
         end
      end

   // Per-port status and link-loss forwarding, purely combinational
   logic [NPORTS-1:0] lost;
   logic [NPORTS-1:0] llf_off;
   assign lost = ~link_up | rx_loss;
   assign vlan_tag_en = (mux_reg == port_ctl_pkg::MUX_VLAN);

   always_comb
   begin
      for (int t = 0; t < NPORTS; t++)
      begin
         // Empty mask never forces; single source makes AND equal to OR
         if (llf_mask_reg[t] == '0)
            llf_off[t] = 1'b0;
         else if (llf_and_reg[t])
            llf_off[t] = ((lost & llf_mask_reg[t]) == llf_mask_reg[t]);
         else
            llf_off[t] = |(lost & llf_mask_reg[t]);
      end
   end

   always_comb
   begin
      for (int p = 0; p < NPORTS; p++)
      begin
         port_ctl_pkg::speed_sel_t s;
         logic fiber;
         s = spd_reg[p];
         fiber = (p < FIBER_N);
         if (p == UPLINK && (mux_reg == port_ctl_pkg::MUX_SWITCH || mux_reg == port_ctl_pkg::MUX_SWITCH_ISO
                             || mux_reg == port_ctl_pkg::MUX_VLAN))
            s = port_ctl_pkg::SPD_2G5;
         // Settings a port type cannot do fall back to auto
         if (fiber && (s == port_ctl_pkg::SPD_10H || s == port_ctl_pkg::SPD_10F || s == port_ctl_pkg::SPD_100H))
            s = port_ctl_pkg::SPD_AUTO;
         if (!fiber && s == port_ctl_pkg::SPD_2G5)
            s = port_ctl_pkg::SPD_AUTO;
         port_enable[p] = (s != port_ctl_pkg::SPD_DISABLED);
         stat[p].laser_off = fiber && laser_reg[p] && rx_loss[p];
         stat[p].up = link_up[p] && port_enable[p];
         stat[p].tx_on = port_enable[p] && !llf_off[p] && !stat[p].laser_off;
         case (s)
            port_ctl_pkg::SPD_AUTO:
            begin
               stat[p].rate = aneg[p].rate;
               stat[p].full_dx = fiber ? 1'b1 : aneg[p].full_dx;
            end
            port_ctl_pkg::SPD_10H:  begin stat[p].rate = port_ctl_pkg::RATE_10;  stat[p].full_dx = 1'b0; end
            port_ctl_pkg::SPD_10F:  begin stat[p].rate = port_ctl_pkg::RATE_10;  stat[p].full_dx = 1'b1; end
            port_ctl_pkg::SPD_100H: begin stat[p].rate = port_ctl_pkg::RATE_100; stat[p].full_dx = 1'b0; end
            port_ctl_pkg::SPD_100F: begin stat[p].rate = port_ctl_pkg::RATE_100; stat[p].full_dx = 1'b1; end
            port_ctl_pkg::SPD_1G:   begin stat[p].rate = port_ctl_pkg::RATE_1G;  stat[p].full_dx = 1'b1; end
            port_ctl_pkg::SPD_2G5:  begin stat[p].rate = port_ctl_pkg::RATE_2G5; stat[p].full_dx = 1'b1; end
            default:                begin stat[p].rate = port_ctl_pkg::RATE_10;  stat[p].full_dx = 1'b0; end
         endcase
         stat[p].rx_pause = fc_reg[p] && aneg[p].valid && aneg[p].pause_rx && port_enable[p];
         stat[p].tx_pause = fc_reg[p] && aneg[p].valid && aneg[p].pause_tx && port_enable[p];
         rx_oversize[p] = port_enable[p] && evt[p].rx_frame && (evt[p].rx_len > maxf_reg[p]);
         tx_oversize[p] = port_enable[p] && evt[p].tx_frame && (evt[p].tx_len > maxf_reg[p]);
      end
   end

   // Forwarding matrix; VLAN mode pairs local and remote ports only
   always_comb
   begin
      for (int a = 0; a < NPORTS; a++)
         for (int b = 0; b < NPORTS; b++)
         begin
            fwd_allow[a][b] = (a != b) && port_enable[a] && port_enable[b];
            if (mux_reg == port_ctl_pkg::MUX_SWITCH_ISO && a != UPLINK && b != UPLINK)
               fwd_allow[a][b] = 1'b0;
            if (mux_reg == port_ctl_pkg::MUX_VLAN && a != UPLINK && b != UPLINK)
               fwd_allow[a][b] = 1'b0;
         end
   end

   // Collision counting per port
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         coll_reg <= '0;
         tx_frame_drop <= '0;
         backoff_restart <= '0;
      end
      else
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            tx_frame_drop[p] <= 1'b0;
            backoff_restart[p] <= 1'b0;
            if (evt[p].tx_done || !port_enable[p])
               coll_reg[p] <= 5'h00;
            else if (evt[p].collision)
            begin
               if (coll_reg[p] + 5'h01 == `COLL_LIMIT)
               begin
                  coll_reg[p] <= 5'h00;
                  tx_frame_drop[p] <= !restart_reg[p];
                  backoff_restart[p] <= restart_reg[p];
               end
               else
                  coll_reg[p] <= coll_reg[p] + 5'h01;
            end
         end
      end

   // Counters: rx/tx pkts, rx/tx bytes, rx/tx err, rx/tx drop; filtered in its own word
   logic [CNT_W-1:0] filt_reg [NPORTS];
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         for (int i = 0; i < NPORTS*NCNT; i++)
            cnt_reg[i] <= '0;
         for (int p = 0; p < NPORTS; p++)
            filt_reg[p] <= '0;
      end
      else if (clr_pulse)
      begin
         for (int i = 0; i < NPORTS*NCNT; i++)
            cnt_reg[i] <= '0;
         for (int p = 0; p < NPORTS; p++)
            filt_reg[p] <= '0;
      end
      else
      begin
         for (int p = 0; p < NPORTS; p++)
            if (port_enable[p])
            begin
               if (evt[p].rx_frame)
               begin
                  cnt_reg[p*NCNT+0] <= cnt_reg[p*NCNT+0] + CNT_W'(1);
                  cnt_reg[p*NCNT+2] <= cnt_reg[p*NCNT+2] + CNT_W'(evt[p].rx_len);
               end
               if (evt[p].tx_frame)
               begin
                  cnt_reg[p*NCNT+1] <= cnt_reg[p*NCNT+1] + CNT_W'(1);
                  cnt_reg[p*NCNT+3] <= cnt_reg[p*NCNT+3] + CNT_W'(evt[p].tx_len);
               end
               if (evt[p].rx_err || rx_oversize[p])
                  cnt_reg[p*NCNT+4] <= cnt_reg[p*NCNT+4] + CNT_W'(1);
               if (evt[p].tx_incomplete || tx_frame_drop[p])
                  cnt_reg[p*NCNT+5] <= cnt_reg[p*NCNT+5] + CNT_W'(1);
               if (evt[p].rx_drop)
                  cnt_reg[p*NCNT+6] <= cnt_reg[p*NCNT+6] + CNT_W'(1);
               if (evt[p].tx_drop)
                  cnt_reg[p*NCNT+7] <= cnt_reg[p*NCNT+7] + CNT_W'(1);
               if (evt[p].rx_filt)
                  filt_reg[p] <= filt_reg[p] + CNT_W'(1);
            end
      end

   // AXI read: one-cycle answer, unmapped gives SLVERR and zero
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb
   begin
      int pi;
      int ci;
      rd_val = 32'h00000000;
      rd_ok = 1'b0;
      pi = 0;
      ci = 0;
      if (s_axi_araddr == `REG_CTRL)
      begin
         rd_ok = 1'b1;
         rd_val[`CTRL_MUX_LSB +: 2] = mux_reg;
      end
      else if (s_axi_araddr >= `REG_CNT_BASE)
      begin
         ci = port_of(s_axi_araddr, `REG_CNT_BASE);
         pi = ci / (NCNT + 1);
         if (pi < NPORTS)
         begin
            rd_ok = 1'b1;
            rd_val = (ci % (NCNT + 1) == NCNT) ? 32'(filt_reg[pi]) : 32'(cnt_reg[pi*NCNT + ci % (NCNT + 1)]);
         end
      end
      else if (s_axi_araddr >= `REG_STAT_BASE)
      begin
         pi = port_of(s_axi_araddr, `REG_STAT_BASE);
         if (pi < NPORTS)
         begin
            rd_ok = 1'b1;
            rd_val[7:0] = stat[pi];
            rd_val[8] = llf_off[pi];
         end
      end
      else if (s_axi_araddr >= `REG_PORT_BASE)
      begin
         pi = port_of(s_axi_araddr, `REG_PORT_BASE);
         if (pi < NPORTS)
         begin
            rd_ok = 1'b1;
            rd_val[`PCFG_SPD_LSB +: 3] = spd_reg[pi];
            rd_val[`PCFG_FC_BIT] = fc_reg[pi];
            rd_val[`PCFG_RESTART_BIT] = restart_reg[pi];
            rd_val[`PCFG_LASER_BIT] = laser_reg[pi];
            rd_val[`PCFG_MAXF_LSB +: 14] = maxf_reg[pi];
         end
      end
      else if (s_axi_araddr >= `REG_LLF_BASE)
      begin
         pi = port_of(s_axi_araddr, `REG_LLF_BASE);
         if (pi < NPORTS)
         begin
            rd_ok = 1'b1;
            rd_val[`LLF_MASK_LSB +: NPORTS] = llf_mask_reg[pi];
            rd_val[`LLF_AND_BIT] = llf_and_reg[pi];
         end
      end
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
endmodule

/* tb/port_ctl_asserts.sv */
`timescale 1ns/100ps
module port_ctl_asserts #(
   parameter int NPORTS = 5
)(
   input wire logic                                   clk,
   input wire logic                                   rst_b,
   input wire logic [NPORTS-1:0]                      link_up,
   input wire logic [NPORTS-1:0]                      rx_loss,
   input wire port_ctl_pkg::aneg_t [NPORTS-1:0]       aneg,
   input wire port_ctl_pkg::port_evt_t [NPORTS-1:0]   evt,
   input wire port_ctl_pkg::port_stat_t [NPORTS-1:0]  stat,
   input wire logic [NPORTS-1:0]                      port_enable,
   input wire logic [NPORTS-1:0]                      tx_frame_drop,
   input wire logic [NPORTS-1:0]                      backoff_restart,
   input wire logic [NPORTS-1:0][NPORTS-1:0]          fwd_allow,
   input wire logic                                   vlan_tag_en
);
   logic [4:0] coll_cnt_reg;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Own tally of port 1 collisions, cleared per frame
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         coll_cnt_reg <= 5'h00;
      else if (evt[1].tx_done)
         coll_cnt_reg <= 5'h00;
      else if (evt[1].collision)
         coll_cnt_reg <= coll_cnt_reg + 5'h01;
   chk_coll_limit: assert property (tx_frame_drop[1] || backoff_restart[1] |-> coll_cnt_reg == 5'h10)
      else $error("collision action not at sixteenth collision");
   chk_drop_single: assert property (tx_frame_drop[1] |-> !backoff_restart[1] ##1 !tx_frame_drop[1])
      else $error("drop pulse malformed");
   chk_laser_cause: assert property (stat[1].laser_off |-> rx_loss[1])
      else $error("laser off without receive loss");
   chk_uplink_rate: assert property (vlan_tag_en && stat[0].up |-> stat[0].rate == port_ctl_pkg::RATE_2G5)
      else $error("uplink not at top rate in mux mode");
   chk_vlan_isolate: assert property (vlan_tag_en |-> !fwd_allow[1][2] && !fwd_allow[2][1])
      else $error("local ports exchange traffic");
   chk_fiber_duplex: assert property (stat[2].up |-> stat[2].full_dx)
      else $error("fiber port in half duplex");
   chk_pause_cause: assert property (stat[3].rx_pause |-> aneg[3].pause_rx)
      else $error("pause obeyed without negotiation");
   chk_disable_stops: assert property (!port_enable[1] |-> !stat[1].tx_on)
      else $error("disabled port transmits");
   chk_release_tx: assert property (&link_up && !(|rx_loss) && port_enable[1] |-> stat[1].tx_on)
      else $error("transmitter held off without loss");
   cov_drop: cover property (tx_frame_drop[1]);
   cov_restart: cover property (backoff_restart[1]);
   cov_forced_off: cover property (port_enable[1] && !stat[1].tx_on);
endmodule
bind port_link_loss_control port_ctl_asserts #(.NPORTS(NPORTS)) port_ctl_asserts_i (.*);

/* tb/link_partner_model.sv */
`timescale 1ns/100ps
module link_partner_model #(
   parameter int NPORTS = 5
)(
   input  wire logic                              clk,
   input  wire logic [NPORTS-1:0]                 rx_cut,
   input  wire logic [NPORTS-1:0]                 link_cut,
   output      logic [NPORTS-1:0]                 link_up,
   output      logic [NPORTS-1:0]                 rx_loss,
   output      port_ctl_pkg::aneg_t [NPORTS-1:0]  aneg,
   output      port_ctl_pkg::port_evt_t [NPORTS-1:0] evt
);
   assign link_up = ~link_cut;
   assign rx_loss = rx_cut;
   // Offers 1G only, so auto lands below the fiber maximum
   assign aneg = {NPORTS{port_ctl_pkg::aneg_t'({1'h1, port_ctl_pkg::RATE_1G, 1'h1, 1'h1, 1'h0})}};
   initial evt = '0;
   task automatic send(input int p, input port_ctl_pkg::port_evt_t e);
      @(posedge clk);
      evt[p] <= e;
      @(posedge clk);
      evt[p] <= '0;
   endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [11:0] a;
      logic [11:0] d;
      logic        lnk;
      logic [4:0]  cut;
      logic [2:0]  p;
      logic [7:0]  e;
   } row_t;
   row_t rows [12] = '{
      {12'h014, 12'h01C, 1'h1, 5'h04, 3'h1, 8'hD0}, {12'h014, 12'h01C, 1'h0, 5'h04, 3'h1, 8'hD0},
      {12'h014, 12'h01C, 1'h0, 5'h00, 3'h1, 8'hD8}, {12'h014, 12'h11C, 1'h0, 5'h04, 3'h1, 8'hD8},
      {12'h014, 12'h11C, 1'h0, 5'h1C, 3'h1, 8'hD0}, {12'h014, 12'h108, 1'h0, 5'h08, 3'h1, 8'hD0},
      {12'h014, 12'h008, 1'h0, 5'h08, 3'h1, 8'hD0}, {12'h014, 12'h008, 1'h0, 5'h10, 3'h1, 8'hD8},
      {12'h04C, 12'h002, 1'h0, 5'h00, 3'h3, 8'h88}, {12'h04C, 12'h005, 1'h0, 5'h00, 3'h3, 8'hB8},
      {12'h04C, 12'h011, 1'h0, 5'h00, 3'h3, 8'hDC}, {12'h048, 12'h007, 1'h0, 5'h00, 3'h2, 8'hF8}};
   logic                          clk = 1'h0, rst_b = 1'h0;
   logic [11:0]                   s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0]                   s_axi_wdata = 32'h00000000, s_axi_rdata, rd_val;
   logic [3:0]                    s_axi_wstrb = 4'hF;
   logic                          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic                          s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, vlan_tag_en;
   logic                          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]                    s_axi_bresp, s_axi_rresp, rsp;
   logic [4:0]                    rx_cut = 5'h00, link_cut = 5'h00, link_up, rx_loss, port_enable;
   logic [4:0]                    tx_frame_drop, backoff_restart, rx_oversize, tx_oversize;
   logic [4:0][4:0]               fwd_allow;
   port_ctl_pkg::aneg_t [4:0]     aneg;
   port_ctl_pkg::port_evt_t [4:0] evt;
   port_ctl_pkg::port_stat_t [4:0] stat;
   int                            fails = 0, cmp_count = 0, cyc = 0, ndrop = 0, nrst = 0, nover = 0;
   int                            cnt_exp [9] = '{2, 1, 200, 64, 1, 1, 1, 1, 1};
   // Bit positions inside the event struct
   localparam int RXF = 36, RXE = 35, RXD = 34, RXFL = 33, TXF = 18, TXD = 17, TXI = 16, COL = 1, TXDN = 0;
   port_link_loss_control port_link_loss_control_i (.*);
   link_partner_model link_partner_model_i (.*);
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      ndrop += tx_frame_drop[1];
      nrst += backoff_restart[1];
      nover += tx_oversize[1];
      if (cyc == 20000)
      begin
         fails++;
         give_verdict();
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
         rsp = s_axi_bresp;
      end
      while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
         rd_val = s_axi_rdata;
         rsp = s_axi_rresp;
      end
      while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk($sformatf("register %h", a), rd_val, e);
   endtask
   task ev(input int b, input logic [13:0] len);
      port_ctl_pkg::port_evt_t e;
      e = '0;
      e[b] = 1'h1;
      e.rx_len = len;
      e.tx_len = len;
      link_partner_model_i.send(1, e);
   endtask
   task give_verdict();
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'h1;
      rdc(12'h044, 32'h25800001);
      rdc(12'h014, 32'h00000000);
      rdc(12'hFFC, 32'h00000000);
      chk("read response", rsp, 2);
      wr(12'hFFC, 32'h00000003);
      chk("write response", rsp, 2);
      foreach (rows[i])
      begin
         wr(rows[i].a, {(rows[i].a[6] ? 16'h2580 : 16'h0000), 4'h0, rows[i].d});
         rx_cut <= rows[i].lnk ? 5'h00 : rows[i].cut;
         link_cut <= rows[i].lnk ? rows[i].cut : 5'h00;
         repeat (3) @(posedge clk);
         chk("port status", stat[rows[i].p], rows[i].e);
      end
      ev(RXF, 100);
      ev(RXF, 100);
      ev(TXF, 64);
      ev(RXD, 0);
      ev(TXD, 0);
      ev(RXFL, 0);
      ev(RXE, 0);
      ev(TXI, 0);
      for (int k = 0; k < 9; k++)
         rdc(12'h124 + 12'(4 * k), cnt_exp[k]);
      wr(12'h000, 32'h00000010);
      for (int k = 0; k < 9; k++)
         rdc(12'h124 + 12'(4 * k), 0);
      ev(RXF, 14'h2581);
      ev(RXF, 14'h2580);
      ev(TXF, 14'h2581);
      rdc(12'h134, 1);
      rdc(12'h124, 2);
      chk("tx oversize pulses", nover, 1);
      repeat (15) ev(COL, 0);
      repeat (3) @(posedge clk);
      chk("drop pulses", ndrop, 0);
      ev(COL, 0);
      repeat (3) @(posedge clk);
      chk("drop pulses", ndrop, 1);
      ev(TXDN, 0);
      wr(12'h044, 32'h25800021);
      repeat (16) ev(COL, 0);
      repeat (3) @(posedge clk);
      chk("restart pulses", nrst, 1);
      chk("drop pulses", ndrop, 1);
      ev(TXDN, 0);
      wr(12'h044, 32'h25800001);
      rx_cut <= 5'h02;
      repeat (3) @(posedge clk);
      chk("laser off", stat[1].laser_off, 0);
      wr(12'h044, 32'h25800041);
      repeat (2) @(posedge clk);
      chk("laser off", stat[1].laser_off, 1);
      rx_cut <= 5'h00;
      repeat (3) @(posedge clk);
      chk("laser off", stat[1].laser_off, 0);
      for (int m = 0; m < 4; m++)
      begin
         wr(12'h000, 32'(m));
         repeat (2) @(posedge clk);
         chk("vlan tagging", vlan_tag_en, m == 3);
         chk("local forwarding", fwd_allow[1][2], m < 2);
         chk("uplink rate", stat[0].rate, m == 0 ? port_ctl_pkg::RATE_1G : port_ctl_pkg::RATE_2G5);
      end
      wr(12'h044, 32'h25800000);
      repeat (2) @(posedge clk);
      chk("port enable", port_enable[1], 0);
      ev(RXF, 100);
      rdc(12'h124, 2);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      rdc(12'h044, 32'h25800001);
      rdc(12'h124, 0);
      give_verdict();
   end
endmodule
